// [hw/dcs_slave.sv]
// daisy-chain serial slave: shifter, frame check, error flag, register write
`timescale 1ns/1ps
module dcs_slave
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    // serial pins from the master
    input wire logic I_MASTER_CHIP_SELECT_N,
    input wire logic I_SCLK,
    input wire logic I_MASTER_SERIAL_OUT,
    // serial output pin
    output logic O_MASTER_SERIAL_IN,
    output logic O_MASTER_SERIAL_IN_OE,
    // device side
    input wire logic I_SLEEP,
    input wire logic [WORD_W-1:0] I_RESPONSE,
    output logic O_WRITE_STB,
    output dcs_pkg::dcs_word_s O_WRITE_WORD,
    output logic O_TRANSFER_ERROR_FLAG
);
    import dcs_pkg::*;

    logic rst_a_r;
    logic rst_b_r;
    logic rst_n;
    dcs_pins_s pin;
    logic sel_d_r;
    logic sclk_d_r;
    logic active_r;
    logic active_nxt;
    logic [WORD_W-1:0] sh_r;
    logic [WORD_W-1:0] sh_nxt;
    logic first_r;
    logic first_nxt;
    logic ter_r;
    logic ter_nxt;
    logic so_r;
    logic so_nxt;
    logic oe_r;
    logic oe_nxt;
    logic stb_r;
    logic stb_nxt;
    dcs_word_s wr_r;
    dcs_word_s wr_nxt;
    logic sel_fall;
    logic sel_rise;
    logic clk_rise;
    logic clk_fall;
    logic frame_ok;

    // reset release through two flops
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end
    assign rst_n = rst_b_r;

    dcs_sync u_sync_sel (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_pin(~I_MASTER_CHIP_SELECT_N),
        .o_level(pin.sel_n)
    );
    dcs_sync u_sync_clk (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_SCLK),
        .o_level(pin.sclk)
    );
    dcs_sync u_sync_sdi (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_MASTER_SERIAL_OUT),
        .o_level(pin.sdi)
    );

    // pin.sel_n holds the selected level (high while chip select is low)
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            sel_d_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            sel_d_r <= pin.sel_n;
            sclk_d_r <= pin.sclk;
        end
    end

    assign sel_fall = pin.sel_n && !sel_d_r;
    assign sel_rise = !pin.sel_n && sel_d_r;
    // edges only count inside an active frame, so idle clocking is ignored
    assign clk_rise = active_r && pin.sclk && !sclk_d_r;
    assign clk_fall = active_r && !pin.sclk && sclk_d_r;

    dcs_frame_check u_frame (
        .i_clk(I_CORE_CLK),
        .i_rst_n(rst_n),
        .i_start(sel_fall),
        .i_tick(clk_fall),
        .o_valid(frame_ok)
    );

    always_comb begin
        active_nxt = active_r;
        sh_nxt = sh_r;
        first_nxt = first_r;
        ter_nxt = ter_r;
        so_nxt = so_r;
        oe_nxt = oe_r;
        stb_nxt = 1'b0;
        wr_nxt = wr_r;
        if (sel_fall) begin
            if (I_SLEEP) begin
                active_nxt = 1'b0;
                oe_nxt = 1'b0;
            end else begin
                active_nxt = 1'b1;
                sh_nxt = I_RESPONSE;
                first_nxt = 1'b1;
                oe_nxt = 1'b1;
                so_nxt = ter_r | pin.sdi;
            end
        end else if (sel_rise) begin
            active_nxt = 1'b0;
            oe_nxt = 1'b0;
            if (active_r) begin
                if (frame_ok) begin
                    stb_nxt = 1'b1;
                    wr_nxt = sh_r;
                end else begin
                    ter_nxt = 1'b1;
                end
            end
        end else if (active_r) begin
            if (first_r) begin
                so_nxt = ter_r | pin.sdi;
            end
            if (clk_rise) begin
                first_nxt = 1'b0;
                // error stays on the first bit until it has been clocked out, then clears
                if (first_r) begin
                    ter_nxt = 1'b0;
                end
                so_nxt = sh_r[WORD_W-1];
            end
            if (clk_fall) begin
                // msb leaves first, new bit enters at lsb: pass-through stage
                sh_nxt = {sh_r[WORD_W-2:0], pin.sdi};
            end
        end
        // an error raised while idle would never be overwritten by the first-bit path
        if (!active_nxt && !sel_fall) begin
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            active_r <= 1'b0;
            sh_r <= SHIFT_RESET;
            first_r <= 1'b0;
            ter_r <= 1'b0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
            stb_r <= 1'b0;
            wr_r <= '0;
        end else begin
            active_r <= active_nxt;
            sh_r <= sh_nxt;
            first_r <= first_nxt;
            ter_r <= ter_nxt;
            so_r <= so_nxt;
            oe_r <= oe_nxt;
            stb_r <= stb_nxt;
            wr_r <= wr_nxt;
        end
    end

    assign O_MASTER_SERIAL_IN = so_r;
    assign O_MASTER_SERIAL_IN_OE = oe_r;
    assign O_WRITE_STB = stb_r;
    assign O_WRITE_WORD = wr_r;
    assign O_TRANSFER_ERROR_FLAG = ter_r;
endmodule

// [hw/dcs_pkg.sv]
// constants and carrier types of the daisy-chain serial slave
// Operation
// - four-line full-duplex serial slave only
// - chip select fall starts access, clears count
// - sample input on fall, output after rise
// - accept only 16 plus multiple-of-8 clocks
// - bad count sets error, discards command
// - select high: ignore clock, output hi-z
// - select fall loads response into shifter
// - first output bit is error OR input
// - sleep keeps output hi-z, no transfer
// - valid end writes data to addressed register
// - input words msb first, control first
// - output words shifted msb first
// - one shift register, pass-through chain stage
package dcs_pkg;
    localparam int WORD_W = 16;
    localparam int CTRL_W = 8;
    localparam int DATA_W = WORD_W - CTRL_W;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] FIRST_WORD_BITS = 16'h0010;
    localparam logic [2:0] BYTE_MASK = 3'h7;
    localparam logic [WORD_W-1:0] SHIFT_RESET = 16'h0000;

    typedef struct packed {
        logic [CTRL_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dcs_word_s;

    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic sdi;
    } dcs_pins_s;
endpackage

// [hw/dcs_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module dcs_sync (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // pin and filtered level
    input wire logic i_pin,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic lvl_nxt;

    always_comb begin
        lvl_nxt = lvl_r;
        if (s2_r == s3_r) begin
            lvl_nxt = s3_r;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            lvl_r <= 1'b0;
        end else begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign o_level = lvl_r;
endmodule

// [hw/dcs_frame_check.sv]
// clock counter judging whether a frame length is acceptable
`timescale 1ns/1ps
module dcs_frame_check
    import dcs_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // events
    input wire logic i_start,
    input wire logic i_tick,
    // verdict
    output logic o_valid
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_start) begin
            cnt_nxt = '0;
        end else if (i_tick && cnt_r != '1) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // 16, 24, 32 ... clocks; saturation keeps runaway frames invalid
    assign o_valid = (cnt_r >= FIRST_WORD_BITS) && ((cnt_r[2:0] & BYTE_MASK) == 3'h0)
        && (cnt_r != '1);
endmodule

// [dv/dcs_slave_properties.sv]
// port checker for the daisy-chain serial slave
`timescale 1ns/1ps
module dcs_slave_properties
    import dcs_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic I_MASTER_CHIP_SELECT_N,
    input wire logic I_MASTER_SERIAL_OUT,
    input wire logic I_SLEEP,
    input wire logic O_MASTER_SERIAL_IN,
    input wire logic O_MASTER_SERIAL_IN_OE,
    input wire logic O_WRITE_STB,
    input wire dcs_pkg::dcs_word_s O_WRITE_WORD,
    input wire logic O_TRANSFER_ERROR_FLAG
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    wire sel = !I_MASTER_CHIP_SELECT_N;
    wire oe = O_MASTER_SERIAL_IN_OE;
    wire stb = O_WRITE_STB;
    wire transfer_error_flag = O_TRANSFER_ERROR_FLAG;
    wire sdi = I_MASTER_SERIAL_OUT;
    AST_OE_IDLE: assert property (!sel [*8] |-> !oe)
        else $error("output enabled while deselected");
    AST_OE_SELECTED: assert property ($rose(oe) |-> sel)
        else $error("output enabled without select");
    AST_FIRST_BIT: assert property ($rose(oe) |-> O_MASTER_SERIAL_IN == ($past(transfer_error_flag) | sdi))
        else $error("first bit is not error or input");
    AST_SLEEP: assert property ($rose(sel) && I_SLEEP |-> (!oe && !stb) [*8])
        else $error("transfer while asleep");
    AST_STB_DESEL: assert property (stb |-> !sel)
        else $error("write strobe while selected");
    AST_STB_PULSE: assert property (stb |=> !stb)
        else $error("write strobe longer than one cycle");
    AST_WORD_HOLD: assert property ($changed(O_WRITE_WORD) |-> stb)
        else $error("write word changed without strobe");
    AST_ERR_END: assert property ($rose(transfer_error_flag) |-> !sel && !stb)
        else $error("error flag raised mid frame or with strobe");
    cover property (stb);
    cover property ($rose(transfer_error_flag));
    cover property ($rose(sel) && I_SLEEP);
endmodule

bind dcs_slave dcs_slave_properties dcs_slave_properties_inst (.I_CORE_CLK, .I_RESET_N,
    .I_MASTER_CHIP_SELECT_N, .I_MASTER_SERIAL_OUT, .I_SLEEP, .O_MASTER_SERIAL_IN,
    .O_MASTER_SERIAL_IN_OE, .O_WRITE_STB, .O_WRITE_WORD, .O_TRANSFER_ERROR_FLAG);

// [dv/dcs_master_model.sv]
// serial master model: whole frames, msb first, clock idle low
`timescale 1ns/1ps
module dcs_master_model (
    output logic o_sel_n,
    output logic o_sclk,
    output logic o_sdo,
    input wire logic i_sdi,
    input wire logic i_oe
);
    localparam time HALF = 32ns;
    logic oe_seen = 1'b0;
    initial {o_sel_n, o_sclk, o_sdo} = 3'b100;
    always @(posedge i_oe) oe_seen = 1'b1;
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx,
                        output logic first);
        oe_seen = 1'b0;
        rx = 32'h0;
        o_sdo = tx[n-1];
        #(HALF) o_sel_n = 1'b0;
        #(3*HALF) first = i_sdi;
        for (int i = n - 1; i >= 0; i--) begin
            o_sdo = tx[i];
            #(HALF) o_sclk = 1'b1;
            #(HALF) o_sclk = 1'b0;
            // sample late: the slave needs several core clocks to show the new bit
            #(HALF - 4ns) rx = {rx[30:0], i_sdi};
            #4ns;
        end
        #(HALF) o_sel_n = 1'b1;
        // no longer sampled: show the inverse rather than a stale level
        o_sdo = ~o_sdo;
        #(4*HALF);
    endtask
endmodule

// [dv/dcs_slave_tb.sv]
// self-checking bench for the daisy-chain serial slave
`timescale 1ns/1ps
module dcs_slave_tb;
    import dcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep = 1'b0;
    logic [WORD_W-1:0] resp = 16'h0000;
    logic sel_n, sclk, sdo, so, oe, stb, transfer_error_flag;
    dcs_word_s word;
    wire so_pin = oe ? so : 1'bz;
    int failures = 0;
    int checked = 0;
    int stbs = 0;
    always #4 clk = ~clk;
    always @(negedge clk) if (stb) stbs++;
    dcs_slave dcs_slave_inst (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
        .I_MASTER_CHIP_SELECT_N(sel_n), .I_SCLK(sclk), .I_MASTER_SERIAL_OUT(sdo),
        .O_MASTER_SERIAL_IN(so), .O_MASTER_SERIAL_IN_OE(oe), .I_SLEEP(sleep),
        .I_RESPONSE(resp), .O_WRITE_STB(stb), .O_WRITE_WORD(word),
        .O_TRANSFER_ERROR_FLAG(transfer_error_flag));
    dcs_master_model dcs_master_model_inst (.o_sel_n(sel_n), .o_sclk(sclk), .o_sdo(sdo),
        .i_sdi(so_pin), .i_oe(oe));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one frame of n clocks; shifter starts with resp, so the stream out is resp then tx
    task automatic frame(input logic [31:0] tx, input int n);
        logic [31:0] rx;
        logic first;
        logic ter0;
        logic ok;
        logic [47:0] w;
        int s0;
        ter0 = transfer_error_flag;
        s0 = stbs;
        ok = n >= 16 && n % 8 == 0;
        @(negedge clk) resp = tx[31:16] ^ 16'ha5c3;
        dcs_master_model_inst.xfer(tx, n, rx, first);
        w = {resp, tx << (32 - n)};
        check(first, ter0 | tx[n-1]);
        check(rx, 32'(w >> (48 - n)));
        check(stbs - s0, ok);
        check(transfer_error_flag, !ok);
        if (ok) check(word, tx[15:0]);
        check(oe, 1'b0);
        $display("frame of %0d clocks done", n);
    endtask
    task automatic sleep_frame();
        logic [31:0] rx;
        logic first;
        logic ter0;
        int s0;
        ter0 = transfer_error_flag;
        s0 = stbs;
        @(negedge clk) sleep = 1'b1;
        dcs_master_model_inst.xfer(32'h0000_1234, 16, rx, first);
        check(dcs_master_model_inst.oe_seen, 1'b0);
        check(stbs - s0, 0);
        check(transfer_error_flag, ter0);
        @(negedge clk) sleep = 1'b0;
        $display("sleep frame done");
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        frame(32'h0000_5a3c, 16);
        frame(32'h0000_0e71, 12);
        sleep_frame();
        frame(32'h0069_c3b4, 24);
        frame(32'h0000_7f0d, 15);
        frame(32'h9e37_1b2c, 32);
        frame(32'h0052_8ad1, 23);
        frame(32'h0000_00c6, 8);
        frame(32'h0000_ffff, 16);
        summarize();
    end
    initial begin
        #500us;
        failures++;
        summarize();
    end
endmodule
